// ### core/sba_cfg.svh
// Constants for the shared bus arbitration and host port block.
`ifndef SBA_CFG_SVH
`define SBA_CFG_SVH
`define SBA_NUM_PROC 6
`define SBA_ID_W 3
`define SBA_ID_SINGLE 3'h0
`define SBA_DMA_CH1 4'h7
`define SBA_DMA_CH2 4'h8
`define SBA_LAST_INIT 3'h6
`endif

// ### core/sba_pkg.sv
// Types shared by both ends of the shared bus arbitration block.
package sba_pkg;
  typedef enum logic [1:0] {
    SBA_IDLE,
    SBA_MASTER,
    SBA_HOST,
    SBA_SLAVE
  } sba_own_type;
endpackage : sba_pkg

// ### core/sba_if.sv
// Interface joining the processor end and the system (host and peers) end.
`timescale 1ns/1ps
interface sba_if;
  logic host_bus_request_n;
  logic chip_select_n;
  logic host_bus_grant_n;
  logic host_bus_grant_oe_n;
  logic host_ready_out;
  logic host_ready_oe_n;
  logic suspend_bus_tristate_n;
  logic rotating_priority_sel;
  logic [2:0] processor_identity;
  logic [5:0] peer_bus_request_n;
  logic own_bus_request_n;
  logic own_bus_request_oe_n;
  logic ack_from_ext;
  logic ack_to_ext;
  logic ack_oe_n;
  logic core_priority_in_n;
  logic core_priority_access_n;
  logic core_priority_oe_n;
  logic [1:0] ext_dma_request_n;
  logic [1:0] ext_dma_grant_n;
  logic bus_oe_n;
  modport proc (
    input host_bus_request_n, chip_select_n, suspend_bus_tristate_n, rotating_priority_sel,
    input processor_identity, peer_bus_request_n, ack_from_ext, core_priority_in_n, ext_dma_request_n,
    output host_bus_grant_n, host_bus_grant_oe_n, host_ready_out, host_ready_oe_n,
    output own_bus_request_n, own_bus_request_oe_n, ack_to_ext, ack_oe_n,
    output core_priority_access_n, core_priority_oe_n, ext_dma_grant_n, bus_oe_n
  );
  modport sys (
    output host_bus_request_n, chip_select_n, suspend_bus_tristate_n, rotating_priority_sel,
    output processor_identity, peer_bus_request_n, ack_from_ext, core_priority_in_n, ext_dma_request_n,
    input host_bus_grant_n, host_bus_grant_oe_n, host_ready_out, host_ready_oe_n,
    input own_bus_request_n, own_bus_request_oe_n, ack_to_ext, ack_oe_n,
    input core_priority_access_n, core_priority_oe_n, ext_dma_grant_n, bus_oe_n
  );
endinterface : sba_if

// ### core/sba_sync.sv
// Two flip-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module sba_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule : sba_sync

// ### core/sba_proc.sv
// Processor end: distributed arbitration, host port, wait states and DMA handshake.
`timescale 1ns/1ps
`include "sba_cfg.svh"
module sba_proc (
  input wire logic clock_i,
  input wire logic rst_n_i,
  sba_if.proc bus,
  input wire logic access_req_i,
  input wire logic lock_i,
  input wire logic slave_access_i,
  input wire logic slave_wait_i,
  input wire logic host_wait_i,
  input wire logic host_async_access_i,
  input wire logic ready_active_drive_sel_i,
  input wire logic core_priority_req_i,
  input wire logic [1:0] dma_grant_req_i,
  output logic access_done_o,
  output logic bus_master_o,
  output sba_pkg::sba_own_type own_state_o,
  output logic [1:0] dma_request_o,
  output logic core_priority_seen_o
);
  import sba_pkg::*;

  // Fixed priority starts after line six, so line one is looked at first.
  localparam logic [2:0] LAST_INIT = `SBA_LAST_INIT;

  // Picks the winning request line after a start position; returns zero when none.
  function automatic logic [2:0] pick_winner(input logic [5:0] req, input logic [2:0] start);
    logic [2:0] win;
    logic [2:0] idx;
    win = 3'h0;
    for (int k = 5; k >= 0; k--) begin
      idx = 3'((int'(start) + k) % 6 + 1);
      if (req[idx - 3'h1]) begin
        win = idx;
      end
    end
    return win;
  endfunction : pick_winner

  logic hbr_n_s;
  logic cs_n_s;
  logic suspend_bus_tristate_n_n_s;
  logic cpa_n_s;
  logic [1:0] dmar_n_s;
  logic [5:0] req_vec;
  logic [2:0] winner;
  logic [2:0] start_pos;
  logic single;

  sba_sync #(.WIDTH(4), .INIT(4'hF)) u_sync_host (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i({bus.host_bus_request_n, bus.chip_select_n, bus.core_priority_in_n, bus.suspend_bus_tristate_n}),
    .sync_o({hbr_n_s, cs_n_s, cpa_n_s, suspend_bus_tristate_n_n_s})
  );

  sba_sync #(.WIDTH(2), .INIT(2'h3)) u_sync_dma (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .async_i(bus.ext_dma_request_n),
    .sync_o(dmar_n_s)
  );

  sba_own_type own_reg, own_next;
  logic [2:0] last_reg, last_next;
  logic req_reg, req_next;
  logic ack_keep_reg, ack_keep_next;
  logic hbg_reg, hbg_next;
  logic ready_reg, ready_next;
  logic [1:0] dmag_reg, dmag_next;
  logic cpa_reg, cpa_next;
  logic done_reg, done_next;
  logic float_reg, float_next;

  assign single = (bus.processor_identity == `SBA_ID_SINGLE);

  // Active request vector, including our own pending request at our own slot.
  always_comb begin
    req_vec = ~bus.peer_bus_request_n;
    if (!single && req_reg) begin
      req_vec[bus.processor_identity - 3'h1] = 1'b1;
    end
  end

  assign start_pos = bus.rotating_priority_sel ? last_reg : LAST_INIT;
  assign winner = pick_winner(req_vec, start_pos);

  // Ownership state and handshake next values.
  always_comb begin
    own_next = own_reg;
    last_next = last_reg;
    req_next = access_req_i | lock_i;
    hbg_next = 1'b1;
    done_next = 1'b0;
    cpa_next = 1'b1;
    float_next = 1'b1;
    ack_keep_next = bus.ack_from_ext;
    ready_next = ~(host_wait_i & host_async_access_i);
    // grants for channels seven and eight
    dmag_next = ~(dma_grant_req_i & ~dmar_n_s);
    case (own_reg)
      SBA_IDLE, SBA_SLAVE: begin
        if (!hbr_n_s) begin
          own_next = SBA_HOST;
        end else if (single ? req_reg : (winner == bus.processor_identity)) begin
          own_next = SBA_MASTER;
          last_next = single ? last_reg : winner;
        end else begin
          own_next = (winner != 3'h0) ? SBA_SLAVE : SBA_IDLE;
          last_next = (winner != 3'h0) ? winner : last_reg;
        end
        cpa_next = ~(core_priority_req_i && own_reg == SBA_SLAVE);
      end
      SBA_MASTER: begin
        if (lock_i) begin
          own_next = SBA_MASTER;
        end else if (!hbr_n_s) begin
          own_next = SBA_HOST;
        end else if (!req_reg) begin
          own_next = SBA_IDLE;
        end
        float_next = ~suspend_bus_tristate_n_n_s;
        done_next = access_req_i & ack_keep_reg & suspend_bus_tristate_n_n_s & ~done_reg;
      end
      SBA_HOST: begin
        hbg_next = hbr_n_s;
        if (hbr_n_s) begin
          own_next = SBA_IDLE;
        end
      end
      default: begin
        own_next = SBA_IDLE;
      end
    endcase
  end

  // Registers all ownership and handshake state.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      own_reg <= SBA_IDLE;
      last_reg <= LAST_INIT;
      req_reg <= 1'b0;
      ack_keep_reg <= 1'b1;
      hbg_reg <= 1'b1;
      ready_reg <= 1'b1;
      dmag_reg <= 2'h3;
      cpa_reg <= 1'b1;
      done_reg <= 1'b0;
      float_reg <= 1'b1;
    end else begin
      own_reg <= own_next;
      last_reg <= last_next;
      req_reg <= req_next;
      ack_keep_reg <= ack_keep_next;
      hbg_reg <= hbg_next;
      ready_reg <= ready_next;
      dmag_reg <= dmag_next;
      cpa_reg <= cpa_next;
      done_reg <= done_next;
      float_reg <= float_next;
    end
  end

  // Pin values and enables toward the shared bus.
  // drive only own line
  assign bus.own_bus_request_n = ~req_reg;
  assign bus.own_bus_request_oe_n = single;
  assign bus.bus_oe_n = (own_reg != SBA_MASTER) | float_reg;
  assign bus.host_bus_grant_n = hbg_reg;
  assign bus.host_bus_grant_oe_n = (own_reg != SBA_HOST);
  // ready only with select and request
  assign bus.host_ready_out = ready_reg;
  assign bus.host_ready_oe_n = cs_n_s | hbr_n_s | (ready_reg & ~ready_active_drive_sel_i);
  assign bus.ack_to_ext = 1'b0;
  assign bus.ack_oe_n = ~(slave_access_i & slave_wait_i);
  assign bus.core_priority_access_n = 1'b0;
  assign bus.core_priority_oe_n = cpa_reg;
  assign bus.ext_dma_grant_n = dmag_reg;

  // Status mirrored back to the core side.
  assign access_done_o = done_reg;
  assign bus_master_o = (own_reg == SBA_MASTER);
  assign own_state_o = own_reg;
  assign dma_request_o = ~dmar_n_s;
  assign core_priority_seen_o = ~cpa_n_s;
endmodule : sba_proc

// ### core/sba_sys.sv
// System end: host, peer requests, memory acknowledge and DMA requesters as logic.
`timescale 1ns/1ps
`include "sba_cfg.svh"
module sba_sys (
  input wire logic clock_i,
  input wire logic rst_n_i,
  sba_if.sys bus,
  input wire logic host_want_i,
  input wire logic host_select_i,
  input wire logic suspend_i,
  input wire logic rotate_i,
  input wire logic [2:0] identity_i,
  input wire logic [5:0] peer_req_i,
  input wire logic mem_wait_i,
  input wire logic core_prio_i,
  input wire logic [1:0] dma_req_i,
  output logic host_granted_o,
  output logic host_ready_o,
  output logic [1:0] dma_granted_o
);
  import sba_pkg::*;

  logic [2:0] id_reg;
  logic [2:0] id_next;
  logic started_reg;
  logic started_next;
  logic host_req_reg;
  logic host_req_next;
  logic granted_reg;
  logic granted_next;

  always_comb begin
    id_next = started_reg ? id_reg : identity_i;
    started_next = 1'b1;
    host_req_next = host_want_i | (~granted_reg & host_req_reg);
    granted_next = host_req_reg & ~bus.host_bus_grant_oe_n & ~bus.host_bus_grant_n;
  end

  // Registers the system side state.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      id_reg <= 3'h0;
      started_reg <= 1'b0;
      host_req_reg <= 1'b0;
      granted_reg <= 1'b0;
    end else begin
      id_reg <= id_next;
      started_reg <= started_next;
      host_req_reg <= host_req_next;
      granted_reg <= granted_next;
    end
  end

  assign bus.host_bus_request_n = ~host_req_reg;
  assign bus.chip_select_n = ~host_select_i;
  assign bus.suspend_bus_tristate_n = ~suspend_i;
  assign bus.rotating_priority_sel = rotate_i;
  // The identity follows its input until the first clock edge after reset ends, then stays frozen.
  assign bus.processor_identity = started_reg ? id_reg : identity_i;
  assign bus.peer_bus_request_n = ~peer_req_i;
  assign bus.ack_from_ext = ~mem_wait_i & (bus.ack_oe_n | bus.ack_to_ext);
  assign bus.core_priority_in_n = ~core_prio_i & (bus.core_priority_oe_n | bus.core_priority_access_n);
  assign bus.ext_dma_request_n = ~dma_req_i;
  assign host_granted_o = granted_reg;
  assign host_ready_o = bus.host_ready_oe_n | bus.host_ready_out;
  assign dma_granted_o = ~bus.ext_dma_grant_n;
endmodule : sba_sys

// ### tb/sba_props.sv
// Concurrent checks on the wires between the processor end and the system end.
`timescale 1ns/1ps
module sba_props (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic host_bus_request_n,
  input wire logic chip_select_n,
  input wire logic host_bus_grant_n,
  input wire logic host_bus_grant_oe_n,
  input wire logic host_ready_oe_n,
  input wire logic suspend_bus_tristate_n,
  input wire logic [2:0] processor_identity,
  input wire logic own_bus_request_oe_n,
  input wire logic ack_to_ext,
  input wire logic ack_oe_n,
  input wire logic core_priority_access_n,
  input wire logic core_priority_oe_n,
  input wire logic [1:0] ext_dma_request_n,
  input wire logic [1:0] ext_dma_grant_n,
  input wire logic bus_oe_n
);
  // Every check samples on the rising edge and rests while reset is low.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_grant_cause; !host_bus_grant_n |-> !$past(host_bus_request_n, 3); endproperty
  a_grant_cause: assert property (p_grant_cause) else $error("grant without host request");
  property p_grant_drive; !host_bus_grant_n |-> !host_bus_grant_oe_n && bus_oe_n; endproperty
  a_grant_drive: assert property (p_grant_drive) else $error("grant undriven or bus driven");
  property p_suspend_bus_tristate_n_float; (!suspend_bus_tristate_n) [*5] |-> bus_oe_n; endproperty
  a_suspend_bus_tristate_n_float: assert property (p_suspend_bus_tristate_n_float) else $error("bus driven while suspended");
  property p_ready_cause; !host_ready_oe_n |-> (!$past(chip_select_n, 2) && !$past(host_bus_request_n, 2))
    || (!$past(chip_select_n, 3) && !$past(host_bus_request_n, 3)); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready driven without select");
  property p_single_quiet; processor_identity == 3'h0 |-> own_bus_request_oe_n; endproperty
  a_single_quiet: assert property (p_single_quiet) else $error("request line driven in single mode");
  property p_ack_od; !ack_oe_n |-> !ack_to_ext; endproperty
  a_ack_od: assert property (p_ack_od) else $error("acknowledge driven high");
  property p_cpa_od; !core_priority_oe_n |-> !core_priority_access_n; endproperty
  a_cpa_od: assert property (p_cpa_od) else $error("core priority driven high");
  property p_dma_one; !ext_dma_grant_n[0] |-> !$past(ext_dma_request_n[0], 3); endproperty
  a_dma_one: assert property (p_dma_one) else $error("first dma grant without request");
  property p_dma_two; !ext_dma_grant_n[1] |-> !$past(ext_dma_request_n[1], 3); endproperty
  a_dma_two: assert property (p_dma_two) else $error("second dma grant without request");
endmodule : sba_props

// ### tb/shared_bus_arbitration_host_port_test.sv
// Testbench joining both ends of the shared bus arbitration block.
`timescale 1ns/1ps
module shared_bus_arbitration_host_port_test;
  import sba_pkg::*;
  logic clock_i, rst_n_i, access_req, lock, s_acc, s_wait, h_wait, h_async, drive_sel, cpa_req;
  logic host_want, host_sel, suspend, mem_wait, done, master, cpa_seen, h_granted, h_ready, rotate;
  logic [1:0] g_req, d_req, d_request, d_granted;
  logic [2:0] identity;
  logic [5:0] peer_req;
  sba_own_type own_state;
  int err_total, total_checks, n;
  typedef struct packed {logic [1:0] dr; logic [1:0] gr; logic sw; logic [1:0] dro; logic [1:0] dg; logic ao;} row_type;
  row_type rows [5] = '{'{2'h0, 2'h3, 1'h0, 2'h0, 2'h0, 1'h1}, '{2'h3, 2'h1, 1'h1, 2'h3, 2'h1, 1'h0},
    '{2'h2, 2'h3, 1'h0, 2'h2, 2'h2, 1'h1}, '{2'h1, 2'h2, 1'h1, 2'h1, 2'h0, 1'h0}, '{2'h3, 2'h3, 1'h0, 2'h3, 2'h3, 1'h1}};
  sba_if bus_if ();
  sba_proc sba_proc_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus(bus_if), .access_req_i(access_req),
    .lock_i(lock), .slave_access_i(s_acc), .slave_wait_i(s_wait), .host_wait_i(h_wait),
    .host_async_access_i(h_async), .ready_active_drive_sel_i(drive_sel), .core_priority_req_i(cpa_req),
    .dma_grant_req_i(g_req), .access_done_o(done), .bus_master_o(master), .own_state_o(own_state),
    .dma_request_o(d_request), .core_priority_seen_o(cpa_seen));
  sba_sys sba_sys_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .bus(bus_if), .host_want_i(host_want),
    .host_select_i(host_sel), .suspend_i(suspend), .rotate_i(rotate), .identity_i(identity), .peer_req_i(peer_req),
    .mem_wait_i(mem_wait), .core_prio_i(1'b0), .dma_req_i(d_req), .host_granted_o(h_granted),
    .host_ready_o(h_ready), .dma_granted_o(d_granted));
  sba_props sba_props_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .host_bus_request_n(bus_if.host_bus_request_n),
    .chip_select_n(bus_if.chip_select_n), .host_bus_grant_n(bus_if.host_bus_grant_n),
    .host_bus_grant_oe_n(bus_if.host_bus_grant_oe_n), .host_ready_oe_n(bus_if.host_ready_oe_n),
    .suspend_bus_tristate_n(bus_if.suspend_bus_tristate_n), .processor_identity(bus_if.processor_identity),
    .own_bus_request_oe_n(bus_if.own_bus_request_oe_n), .ack_to_ext(bus_if.ack_to_ext), .ack_oe_n(bus_if.ack_oe_n),
    .core_priority_access_n(bus_if.core_priority_access_n), .core_priority_oe_n(bus_if.core_priority_oe_n),
    .ext_dma_request_n(bus_if.ext_dma_request_n), .ext_dma_grant_n(bus_if.ext_dma_grant_n), .bus_oe_n(bus_if.bus_oe_n));
  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Waits whole cycles and lands just after the last rising edge.
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : tick
  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // Free running 10 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #(3000 * 100);
    err_total++;
    end_of_test;
  end
  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    {rst_n_i, access_req, lock, s_acc, s_wait, h_wait, h_async, drive_sel, cpa_req} = 9'h020;
    rotate = 1'b0;
    {host_want, host_sel, suspend, mem_wait, g_req, d_req, peer_req} = 14'h0000;
    identity = 3'h3;
    err_total = 0;
    total_checks = 0;
    tick(9);
    chk({bus_if.host_bus_grant_n, bus_if.bus_oe_n, bus_if.ext_dma_grant_n}, 8'h0F);
    chk({done, own_state}, {5'h00, SBA_IDLE});
    @(posedge clock_i) rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clock_i) {d_req, g_req, s_wait} <= {rows[i].dr, rows[i].gr, rows[i].sw};
      tick(5);
      chk({d_request, d_granted, bus_if.ack_oe_n}, {rows[i].dro, rows[i].dg, rows[i].ao});
    end
    @(posedge clock_i) {s_wait, host_want, host_sel, peer_req} <= 9'h0FF;
    for (n = 0; bus_if.host_bus_request_n !== 1'b0 && n < 5; n++) tick(1);
    for (n = 0; bus_if.host_bus_grant_n !== 1'b0 && n < 10; n++) tick(1);
    chk(n, 4);
    tick(1);
    chk(h_granted, 1);
    for (int d = 0; d < 2; d++) begin
      @(posedge clock_i) {h_wait, h_async, drive_sel} <= {2'h3, d[0]};
      tick(3);
      chk({bus_if.host_ready_oe_n, bus_if.host_ready_out, h_ready}, 3'h0);
      @(posedge clock_i) h_wait <= 1'b0;
      tick(3);
      chk({bus_if.host_ready_oe_n, bus_if.host_ready_out | ~d[0], h_ready}, {~d[0], 2'h3});
    end
    @(posedge clock_i) {host_want, h_async, peer_req} <= 8'h00;
    tick(4);
    chk({bus_if.host_bus_grant_n, own_state}, {1'b1, SBA_IDLE});
    @(posedge clock_i) {access_req, cpa_req, peer_req} <= 8'hC1;
    tick(8);
    chk({master, bus_if.core_priority_oe_n, cpa_seen}, 3'h1);
    @(posedge clock_i) {cpa_req, peer_req} <= 7'h30;
    tick(8);
    chk({master, bus_if.own_bus_request_oe_n}, 2'h2);
    @(posedge clock_i) {lock, host_want} <= 2'h3;
    tick(10);
    chk(bus_if.host_bus_grant_n, 1);
    @(posedge clock_i) lock <= 1'b0;
    tick(8);
    chk(bus_if.host_bus_grant_n, 0);
    @(posedge clock_i) {host_want, peer_req} <= 7'h00;
    tick(6);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_i) {mem_wait, suspend} <= {k == 0, k == 1};
      tick(3);
      for (n = 0; n < 10 && done !== 1'b1; n++) tick(1);
      chk(n, 10);
      @(posedge clock_i) {mem_wait, suspend} <= 2'h0;
      for (n = 0; n < 10 && done !== 1'b1; n++) tick(1);
      chk(n < 10, 1);
    end
    @(posedge clock_i) {access_req, rotate, peer_req} <= 8'h41;
    tick(4);
    chk({master, own_state}, {1'b0, SBA_SLAVE});
    @(posedge clock_i) access_req <= 1'b1;
    tick(4);
    chk(master, 1);
    @(posedge clock_i) {rotate, peer_req, rst_n_i, identity} <= 11'h000;
    tick(3);
    @(posedge clock_i) rst_n_i <= 1'b1;
    tick(8);
    chk({master, bus_if.own_bus_request_oe_n}, 2'h3);
    end_of_test;
  end
endmodule : shared_bus_arbitration_host_port_test
